// ==== design/icd_pkg.sv ====
// constants, register map and divider mapping for the interrupt flag and clock dividers
// assumes a 32-bit apb slave port and a single 100 mhz sys_clk domain
package icd_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CODE_W = 3;
  localparam int CNT_W  = 7;
  localparam int ST_W   = 2;

  // register indices; byte address is four times the index
  localparam int IDX_CLKDIV_A = 4;
  localparam int IDX_CLKDIV_B = 5;
  localparam int IDX_CTRL     = 6;
  localparam int IDX_STATUS   = 8;
  localparam int IDX_MASK     = 9;
  localparam int IDX_FLAG     = 10;

  localparam logic [ADDR_W-1:0] ADDR_CLKDIV_A = ADDR_W'(IDX_CLKDIV_A * 4);
  localparam logic [ADDR_W-1:0] ADDR_CLKDIV_B = ADDR_W'(IDX_CLKDIV_B * 4);
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = ADDR_W'(IDX_CTRL * 4);
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = ADDR_W'(IDX_STATUS * 4);
  localparam logic [ADDR_W-1:0] ADDR_MASK     = ADDR_W'(IDX_MASK * 4);
  localparam logic [ADDR_W-1:0] ADDR_FLAG     = ADDR_W'(IDX_FLAG * 4);

  // field positions
  localparam int CAL_LSB = 5;
  localparam int PLL_LSB = 0;
  localparam int IMP_LSB = 4;
  localparam int SEL_BIT = 7;
  localparam int ST_RES  = 0;
  localparam int ST_OVF  = 1;

  // reset values
  localparam logic [7:0]      RST_CLKDIV = 8'h00;
  localparam logic [ST_W-1:0] RST_MASK   = 2'h0;

  typedef enum logic
  {
    SRC_RESULT   = 1'b0,
    SRC_OVERFLOW = 1'b1
  } icd_src_e;

  // division factor of a 3-bit code; impedance clock takes 32 at code 6
  function automatic logic [CNT_W-1:0] icd_div_factor(input logic [CODE_W-1:0] code, input logic imp);
    logic [CNT_W-1:0] f;
    f = 7'h40;
    case (code)
      3'h0: f = 7'h01;
      3'h1: f = 7'h02;
      3'h2: f = 7'h04;
      3'h3: f = 7'h08;
      3'h4: f = 7'h10;
      3'h5: f = 7'h20;
      3'h6: f = imp ? 7'h20 : 7'h40;
      default: f = 7'h40;
    endcase
    return f;
  endfunction

endpackage

// ==== design/icd_clkdiv.sv ====
// one power-of-two divider producing a one-cycle clock tick
// assumes code comes from a register on sys_clk; a new code is taken only at a period boundary
`timescale 1ns/1ps
`default_nettype none

module icd_clkdiv #(
  parameter bit IMP = 1'b0
) (
  input  wire logic                      sys_clk,
  input  wire logic                      arst_n,
  input  wire logic [icd_pkg::CODE_W-1:0] code,
  output var  logic                      tick
);
  import icd_pkg::*;

  typedef struct packed
  {
    logic [CNT_W-1:0]  cnt;
    logic [CODE_W-1:0] code;
    logic              tick;
  } icd_div_s;

  icd_div_s st;
  icd_div_s next_st;
  logic [CNT_W-1:0] fac;

  always_comb
  begin
    next_st = st;
    fac = icd_div_factor(st.code, IMP);
    if (st.cnt >= fac - 7'h01)
    begin
      next_st.cnt  = '0;
      next_st.tick = 1'b1;
      next_st.code = code;
    end
    else
    begin
      next_st.cnt  = st.cnt + 7'h01;
      next_st.tick = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick = st.tick;

  // period tracking for the checks
  logic [CNT_W-1:0] gap;
  logic             armed;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gap   <= '0;
      armed <= 1'b0;
    end
    else if (st.tick)
    begin
      gap   <= '0;
      armed <= 1'b1;
    end
    else
      gap <= gap + 7'h01;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  tick_period_a: assert property ((st.tick && armed) |-> (gap + 7'h01) == icd_div_factor($past(st.code), IMP))
    else $error("divider period does not match code");
  code_at_tick_a: assert property ($changed(st.code) |-> st.tick)
    else $error("divider code changed inside a period");
  tick_alive_a: assert property (st.tick |-> ##[1:64] st.tick)
    else $error("divider tick missing for more than 64 cycles");

endmodule

`default_nettype wire

// ==== design/icd_interrupt_flag_output.sv ====
// interrupt flag with selectable source, held until the init command
// assumes event and init pulses come from logic on sys_clk
`timescale 1ns/1ps
`default_nettype none

module icd_interrupt_flag_output (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic src_sel,
  input  wire logic result_write,
  input  wire logic unit_overflow,
  input  wire logic init_cmd,
  output var  logic flag
);
  import icd_pkg::*;

  typedef struct packed
  {
    logic flag;
  } icd_flag_s;

  icd_flag_s st;
  icd_flag_s next_st;
  logic      hit;

  assign hit = (src_sel == SRC_RESULT) ? result_write : unit_overflow;

  always_comb
  begin
    next_st = st;
    if (hit)
      next_st.flag = 1'b1;
    else if (init_cmd)
      next_st.flag = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign flag = st.flag;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  result_flag_a: assert property ((src_sel == SRC_RESULT && result_write) |=> flag)
    else $error("result write did not raise flag");
  overflow_flag_a: assert property ((src_sel == SRC_OVERFLOW && unit_overflow) |=> flag)
    else $error("overflow did not raise flag");
  flag_source_a: assert property ($rose(flag) |-> $past(hit))
    else $error("flag rose without selected event");
  flag_clear_a: assert property ((init_cmd && !hit) |=> !flag)
    else $error("init did not clear flag");

endmodule

`default_nettype wire

// ==== design/icd_top.sv ====
// apb register file, interrupt flag and three internal clock dividers
// assumes apb master on sys_clk; event and init pulses from logic on sys_clk
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module icd_top (
  input  wire logic                        sys_clk,
  input  wire logic                        arst_n,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [icd_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [icd_pkg::DATA_W-1:0]  pwdata,
  output var  logic [icd_pkg::DATA_W-1:0]  prdata,
  output var  logic                        pready,
  output var  logic                        pslverr,
  input  wire logic                        result_write,
  input  wire logic                        unit_overflow,
  input  wire logic                        init_cmd,
  output var  logic                        interrupt_flag_output,
  output var  logic                        cal_clk_tick,
  output var  logic                        pll_ref_clk_tick,
  output var  logic                        imp_clk_tick,
  output var  logic                        irq
);
  import icd_pkg::*;

  typedef struct packed
  {
    logic [7:0]        div_a;
    logic [7:0]        div_b;
    logic              src_sel;
    logic [ST_W-1:0]   status;
    logic [ST_W-1:0]   mask;
    logic              irq;
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } icd_regs_s;

  icd_regs_s st;
  icd_regs_s next_st;

  logic              acc;
  logic              wr;
  logic              mapped;
  logic [DATA_W-1:0] rd_val;
  logic [ST_W-1:0]   ev;
  logic [ST_W-1:0]   clr;

  // access phase completes when pready is high
  assign acc = psel && penable && st.pready;
  assign wr  = acc && pwrite;

  assign ev[ST_RES] = result_write;
  assign ev[ST_OVF] = unit_overflow;

  // read mux and address decode
  always_comb
  begin
    rd_val = '0;
    mapped = 1'b1;
    if (paddr == ADDR_CLKDIV_A)
      rd_val[7:0] = st.div_a;
    else if (paddr == ADDR_CLKDIV_B)
      rd_val[7:0] = st.div_b;
    else if (paddr == ADDR_CTRL)
      rd_val[SEL_BIT] = st.src_sel;
    else if (paddr == ADDR_STATUS)
      rd_val[ST_W-1:0] = st.status;
    else if (paddr == ADDR_MASK)
      rd_val[ST_W-1:0] = st.mask;
    else if (paddr == ADDR_FLAG)
      rd_val[0] = interrupt_flag_output;
    else
      mapped = 1'b0;
  end

  always_comb
  begin
    next_st = st;
    clr = '0;
    // one wait state, then answer
    next_st.pready = psel && penable && !st.pready;
    if (psel && penable && !st.pready)
    begin
      next_st.pslverr = !mapped;
      next_st.prdata  = pwrite ? '0 : rd_val;
    end
    else
    begin
      next_st.pslverr = 1'b0;
    end
    if (wr && mapped)
    begin
      if (paddr == ADDR_CLKDIV_A)
        next_st.div_a = pwdata[7:0];
      else if (paddr == ADDR_CLKDIV_B)
        next_st.div_b = pwdata[7:0];
      else if (paddr == ADDR_CTRL)
        next_st.src_sel = pwdata[SEL_BIT];
      else if (paddr == ADDR_STATUS)
        clr = pwdata[ST_W-1:0];
      else if (paddr == ADDR_MASK)
        next_st.mask = pwdata[ST_W-1:0];
    end
    // set wins over write-one-to-clear
    next_st.status = (st.status & ~clr) | ev;
    next_st.irq    = |(next_st.status & next_st.mask);
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st         <= '0;
      st.div_a   <= RST_CLKDIV;
      st.div_b   <= RST_CLKDIV;
      st.src_sel <= SRC_RESULT;
      st.mask    <= RST_MASK;
    end
    else
      st <= next_st;
  end

  assign prdata  = st.prdata;
  assign pready  = st.pready;
  assign pslverr = st.pslverr;
  assign irq     = st.irq;

  // flag pin; readout may start on its rising edge
  icd_interrupt_flag_output u_flag (
    .sys_clk       (sys_clk),
    .arst_n        (arst_n),
    .src_sel       (st.src_sel),
    .result_write  (result_write),
    .unit_overflow (unit_overflow),
    .init_cmd      (init_cmd),
    .flag          (interrupt_flag_output)
  );

  // three independent dividers from the reference clock
  icd_clkdiv #(.IMP(1'b0)) u_cal (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .code    (st.div_a[CAL_LSB +: CODE_W]),
    .tick    (cal_clk_tick)
  );

  icd_clkdiv #(.IMP(1'b0)) u_pll (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .code    (st.div_b[PLL_LSB +: CODE_W]),
    .tick    (pll_ref_clk_tick)
  );

  icd_clkdiv #(.IMP(1'b1)) u_imp (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .code    (st.div_b[IMP_LSB +: CODE_W]),
    .tick    (imp_clk_tick)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // apb handshake: one wait state, one-cycle answer
  answer_time_a: assert property ((psel && penable && !st.pready) |=> pready)
    else $error("apb answer late");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  idle_quiet_a: assert property (!psel |=> (!pready && !pslverr))
    else $error("answer without a selected transfer");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr outside the answer cycle");
  unmapped_err_a: assert property ((psel && penable && !st.pready && !mapped) |=> pslverr)
    else $error("unmapped address answered without error");
  mapped_ok_a: assert property ((psel && penable && !st.pready && mapped) |=> !pslverr)
    else $error("mapped address answered with error");

  // read data loaded with the answer, held until the next one
  read_data_a: assert property ((psel && penable && !st.pready && !pwrite)
    |=> prdata == $past(rd_val))
    else $error("read data does not match the register");
  write_data_a: assert property ((psel && penable && !st.pready && pwrite)
    |=> prdata == '0)
    else $error("write answer carries data");
  unmapped_read_a: assert property ((psel && penable && !st.pready && !mapped)
    |=> prdata == '0)
    else $error("unmapped read returned data");
  prdata_hold_a: assert property (!(psel && penable && !st.pready)
    |=> $stable(prdata))
    else $error("read data changed outside an answer");
  ctrl_read_a: assert property ((psel && penable && !st.pready && !pwrite && paddr == ADDR_CTRL)
    |=> prdata == (DATA_W'(st.src_sel) << SEL_BIT))
    else $error("source select not at its bit");
  status_read_a: assert property ((psel && penable && !st.pready && !pwrite && paddr == ADDR_STATUS)
    |=> prdata == DATA_W'($past(st.status)))
    else $error("status read does not match");
  mask_read_a: assert property ((psel && penable && !st.pready && !pwrite && paddr == ADDR_MASK)
    |=> prdata == DATA_W'($past(st.mask)))
    else $error("mask read does not match");
  flag_read_a: assert property ((psel && penable && !st.pready && !pwrite && paddr == ADDR_FLAG)
    |=> prdata == DATA_W'($past(interrupt_flag_output)))
    else $error("flag read does not match the pin");

  // register writes land at the completing edge only
  src_sel_write_a: assert property ((wr && paddr == ADDR_CTRL)
    |=> st.src_sel == $past(pwdata[SEL_BIT]))
    else $error("source select not updated by write");
  div_a_write_a: assert property ((wr && paddr == ADDR_CLKDIV_A)
    |=> st.div_a == $past(pwdata[7:0]))
    else $error("divider register a not updated");
  div_b_write_a: assert property ((wr && paddr == ADDR_CLKDIV_B)
    |=> st.div_b == $past(pwdata[7:0]))
    else $error("divider register b not updated");
  mask_write_a: assert property ((wr && paddr == ADDR_MASK)
    |=> st.mask == $past(pwdata[ST_W-1:0]))
    else $error("mask register not updated");
  cfg_hold_a: assert property (!wr
    |=> ($stable(st.div_a) && $stable(st.div_b) && $stable(st.src_sel) && $stable(st.mask)))
    else $error("configuration changed without a write");
  unmapped_write_a: assert property ((wr && !mapped)
    |=> ($stable(st.div_a) && $stable(st.div_b) && $stable(st.src_sel) && $stable(st.mask)))
    else $error("unmapped write changed a register");

  // sticky status, set wins over clear, level irq
  status_sticky_a: assert property (result_write |=> st.status[ST_RES])
    else $error("result event lost in status");
  status_ovf_a: assert property (unit_overflow |=> st.status[ST_OVF])
    else $error("overflow event lost in status");
  res_clear_a: assert property ((wr && paddr == ADDR_STATUS && pwdata[ST_RES] && !result_write)
    |=> !st.status[ST_RES])
    else $error("result status not cleared");
  ovf_clear_a: assert property ((wr && paddr == ADDR_STATUS && pwdata[ST_OVF] && !unit_overflow)
    |=> !st.status[ST_OVF])
    else $error("overflow status not cleared");
  res_hold_a: assert property ((st.status[ST_RES] && !(wr && paddr == ADDR_STATUS && pwdata[ST_RES]))
    |=> st.status[ST_RES])
    else $error("result status lost");
  ovf_hold_a: assert property ((st.status[ST_OVF] && !(wr && paddr == ADDR_STATUS && pwdata[ST_OVF]))
    |=> st.status[ST_OVF])
    else $error("overflow status lost");
  res_quiet_a: assert property ((!result_write && !st.status[ST_RES]) |=> !st.status[ST_RES])
    else $error("result status set without event");
  ovf_quiet_a: assert property ((!unit_overflow && !st.status[ST_OVF]) |=> !st.status[ST_OVF])
    else $error("overflow status set without event");
  irq_level_a: assert property ((st.status[ST_OVF] && st.mask[ST_OVF]) |-> irq)
    else $error("unmasked status without irq");
  irq_res_a: assert property ((st.status[ST_RES] && st.mask[ST_RES]) |-> irq)
    else $error("unmasked result status without irq");
  irq_off_a: assert property (((st.status & st.mask) == '0) |-> !irq)
    else $error("irq without unmasked status");

  // flag follows only the selected source and holds until init
  flag_res_mode_a: assert property ((st.src_sel == SRC_RESULT && !result_write && !interrupt_flag_output)
    |=> !interrupt_flag_output)
    else $error("flag rose without a result write");
  flag_ovf_mode_a: assert property ((st.src_sel == SRC_OVERFLOW && !unit_overflow && !interrupt_flag_output)
    |=> !interrupt_flag_output)
    else $error("flag rose without an overflow");
  flag_res_set_a: assert property ((st.src_sel == SRC_RESULT && result_write)
    |=> interrupt_flag_output)
    else $error("result write did not raise the flag");
  flag_ovf_set_a: assert property ((st.src_sel == SRC_OVERFLOW && unit_overflow)
    |=> interrupt_flag_output)
    else $error("overflow did not raise the flag");
  flag_hold_a: assert property ((interrupt_flag_output && !init_cmd) |=> interrupt_flag_output)
    else $error("flag dropped without init");
  flag_init_a: assert property ((init_cmd && !result_write && !unit_overflow) |=> !interrupt_flag_output)
    else $error("init did not clear the flag");

  // each derived clock ticks at least once in any 64 cycles
  clocks_alive_a: assert property (cal_clk_tick |-> ##[0:63] pll_ref_clk_tick)
    else $error("pll reference clock stalled");
  imp_alive_a: assert property (cal_clk_tick |-> ##[0:63] imp_clk_tick)
    else $error("impedance clock stalled");
  cal_alive_a: assert property (cal_clk_tick |-> ##[1:64] cal_clk_tick)
    else $error("calibration clock gap above 64");
  pll_alive_a: assert property (pll_ref_clk_tick |-> ##[1:64] pll_ref_clk_tick)
    else $error("pll reference clock gap above 64");
  imp_tick_a: assert property (imp_clk_tick |-> ##[1:64] imp_clk_tick)
    else $error("impedance clock gap above 64");
  cal_div1_a: assert property ((cal_clk_tick && st.div_a[CAL_LSB +: CODE_W] == '0 && $stable(st.div_a))
    |=> cal_clk_tick)
    else $error("calibration code 0 not dividing by one");
  pll_div1_a: assert property ((pll_ref_clk_tick && st.div_b[PLL_LSB +: CODE_W] == '0 && $stable(st.div_b))
    |=> pll_ref_clk_tick)
    else $error("pll code 0 not dividing by one");
  imp_div1_a: assert property ((imp_clk_tick && st.div_b[IMP_LSB +: CODE_W] == '0 && $stable(st.div_b))
    |=> imp_clk_tick)
    else $error("impedance code 0 not dividing by one");

endmodule

`default_nettype wire

// ==== design/README_unused.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== bench/icd_readout_model.sv ====
// readout side model: fetches on a rising flag, then re-arms it with init
// assumes flag is a registered level on sys_clk
`timescale 1ns/1ps
`default_nettype none

module icd_readout_model (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic flag,
  output var  logic init_cmd
);
  logic [2:0] cnt;
  logic       prev;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt      <= 3'h0;
      prev     <= 1'b0;
      init_cmd <= 1'b0;
    end
    else
    begin
      prev     <= flag;
      init_cmd <= (cnt == 3'h1);
      if (flag && !prev)
        cnt <= 3'h4;
      else if (cnt != 3'h0)
        cnt <= cnt - 3'h1;
    end
  end
endmodule

`default_nettype wire

// ==== bench/interrupt_flag_and_clock_dividers_tb_top.sv ====
// bench for flag source, status, mask and the three clock dividers
// assumes icd_top with one wait state apb and a readout model on init_cmd
`timescale 1ns/1ps
`default_nettype none

module interrupt_flag_and_clock_dividers_tb_top;
  import icd_pkg::*;
  logic        sys_clk, arst_n, psel, penable, pwrite, err;
  logic        result_write, unit_overflow, pready, pslverr, init_cmd;
  logic        flag, cal_t, pll_t, imp_t, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  int          failures, comparisons, cycles, n;
  int          cc[3];

  icd_top u_icd_top (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .result_write(result_write), .unit_overflow(unit_overflow),
    .init_cmd(init_cmd), .interrupt_flag_output(flag), .cal_clk_tick(cal_t),
    .pll_ref_clk_tick(pll_t), .imp_clk_tick(imp_t), .irq(irq));

  icd_readout_model u_icd_readout_model (.sys_clk(sys_clk), .arst_n(arst_n),
    .flag(flag), .init_cmd(init_cmd));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic int fac(input int c, input bit imp);
    if (c == 6 && imp)
      return 32;
    return c > 5 ? 64 : 1 << c;
  endfunction

  function automatic logic tk(input int s);
    return s == 0 ? cal_t : (s == 1 ? pll_t : imp_t);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // skip two ticks so a new code is in force, then count one period
  task automatic span(input int s, output int p);
    repeat (3)
    begin
      p = 0;
      do
      begin
        @(negedge sys_clk);
        p++;
      end
      while (tk(s) !== 1'b1 && p < 200);
    end
  endtask

  task automatic ev(input bit ovf, input logic ef, input logic [1:0] es, input logic ei);
    @(posedge sys_clk);
    unit_overflow <= ovf;
    result_write  <= !ovf;
    @(posedge sys_clk);
    unit_overflow <= 1'b0;
    result_write  <= 1'b0;
    @(negedge sys_clk);
    check(flag, ef);
    check(irq, ei);
    rdchk(ADDR_STATUS, es);
    repeat (10) @(posedge sys_clk);
    check(flag, 1'b0);
  endtask

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      conclude();
    end
  end

  initial
  begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    result_write = 1'b0;
    unit_overflow = 1'b0;
    seed = 32'h3;
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    foreach (cc[i])
      rdchk(8'(16 + 4 * i), 32'h0);
    rdchk(ADDR_MASK, 32'h0);
    rdchk(ADDR_FLAG, 32'h0);
    foreach (cc[i])
    begin
      apb(1'b1, i == 0 ? 8'h3C : 8'h11, 32'hFF);
      check(err, 1'b1);
      apb(1'b0, i == 0 ? 8'h3C : 8'h11, 32'h0);
      check({rd[30:0], err}, 32'h1);
    end
    repeat (6)
    begin
      seed = xs(seed);
      apb(1'b1, seed[8] ? ADDR_CLKDIV_A : ADDR_CLKDIV_B, seed);
      rdchk(seed[8] ? ADDR_CLKDIV_A : ADDR_CLKDIV_B, {24'h0, seed[7:0]});
    end
    for (int c = 0; c < 8; c++)
    begin
      cc[0] = c;
      cc[1] = (c + 3) % 8;
      cc[2] = (c + 5) % 8;
      apb(1'b1, ADDR_CLKDIV_A, 32'(cc[0] << CAL_LSB));
      apb(1'b1, ADDR_CLKDIV_B, 32'((cc[2] << IMP_LSB) | (cc[1] << PLL_LSB)));
      for (int s = 0; s < 3; s++)
      begin
        span(s, n);
        check(n, fac(cc[s], s == 2));
      end
    end
    apb(1'b1, ADDR_MASK, 32'h3);
    ev(1'b1, 1'b0, 2'h2, 1'b1);
    ev(1'b0, 1'b1, 2'h3, 1'b1);
    apb(1'b1, ADDR_STATUS, 32'h3);
    rdchk(ADDR_STATUS, 32'h0);
    check(irq, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h80);
    rdchk(ADDR_CTRL, 32'h80);
    ev(1'b0, 1'b0, 2'h1, 1'b1);
    apb(1'b1, ADDR_STATUS, 32'h3);
    apb(1'b1, ADDR_MASK, 32'h1);
    ev(1'b1, 1'b1, 2'h2, 1'b0);
    conclude();
  end
endmodule

`default_nettype wire
